// ===== logic/ext_mem_pkg.sv
// Package for the external memory bus wait and sharing controller
package ext_mem_pkg;
   localparam logic [7:0] WSC_OFFSET      = 8'hfc;
   localparam logic [7:0] MODE_OFFSET     = 8'hec;
   localparam logic [7:0] EXT_IRQ_VECTOR_REG_OFFSET     = 8'hf6;
   localparam logic [7:0] WSC_RESET       = 8'h7f;
   localparam logic [7:0] WSC_WMASK       = 8'h7f;
   localparam logic [1:0] MODE_RESET      = 2'h0;
   localparam int         BUS_FLOAT_BIT   = 0;
   localparam int         BUS_REQ_EN_BIT  = 1;
   localparam int         WAIT_EN_BIT     = 0;
   localparam int         PROG_LSB        = 0;
   localparam int         DATA_LSB        = 3;
   localparam int         WDG_BIT         = 6;
   localparam logic [2:0] PORT_CTRL_ONCHIP  = 3'h0;
   localparam logic [2:0] PORT_CTRL_EXTPROG = 3'h3;
   localparam logic [1:0] REBUS_CYCLES    = 2'h2;
   localparam logic [2:0] STACK_POP_BYTE  = 3'h1;
   localparam logic [2:0] STACK_POP_RET   = 3'h2;
   localparam logic [2:0] STACK_POP_IRET  = 3'h3;
   localparam logic [1:0] PREFETCH_DIV    = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_T1     = 3'b001,
      ST_T2     = 3'b010,
      ST_PWAIT  = 3'b011,
      ST_EWAIT  = 3'b100,
      ST_T3     = 3'b101,
      ST_FLOAT  = 3'b110,
      ST_REDRV  = 3'b111
   } cyc_state_e;

   typedef struct packed {
      logic        valid;
      logic        external;
      logic        program_space;
      logic        write;
      logic [15:0] addr;
   } access_req_s;

   typedef struct packed {
      logic        address_strobe_n;
      logic        data_strobe_n;
      logic        read_write;
      logic        prog_data;
      logic        opcode_fetch_cycle;
      logic        second_byte_fetch_cycle;
      logic [15:0] addr;
   } bus_out_s;
endpackage

// ===== logic/ext_mem_bus_wait_share.sv
// External memory bus controller: wait stretching, bus sharing, reset port setup
// How it works
// - Enabled wait input sampled in phase two; low adds one internal cycle.
// - Wait resampled every added cycle; core clock stays stretched while low.
// - On-chip accesses never get wait cycles, full core clock speed.
// - Separate three-bit program and data wait counts add 0 to 7 cycles.
// - Count value is plain binary number of added cycles.
// - Wait register bits 5..3 hold data wait count, internal clock units.
// - Wait register bits 2..0 hold program wait count, external program only.
// - Wait register resets to 7Fh: seven waits for both spaces.
// - Wait register top bit reserved, reads zero.
// - With enable set, bus request sampled in phase three.
// - Request low stretches core clock and floats strobes, direction, ports.
// - Request high: drive bus again, wait two cycles, restart core clock.
// - Bus acknowledge low for whole floated interval.
// - Reset clears bus request enable; software enables sharing itself.
// - Float bit floats strobes, direction and non-I/O ports; core continues.
// - With on-chip program memory ports reset to weak pull-up, data one.
// - Without on-chip program or strap low, ports reset alternate push-pull.
// - External program strap latched at reset release; low forces external fetch.
// - Opcode and second byte fetches marked as separate machine cycles.
// - After divide, next code byte fetched twice unless overflow or zero trap.
// - Internal stack pops issue discarded data reads: one, two or three.
// - Wait input only acts when its enable bit is set.
// - Data strobe low in phase two only for external accesses.
//
// Added by the designer: the APB slave port.
module ext_mem_bus_wait_share
   import ext_mem_pkg::*;
#(
   parameter bit HAS_ONCHIP_PROG = 1'b1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire access_req_s req,
   input  wire logic        req_opcode,
   input  wire logic        req_second,
   input  wire logic        div_done,
   input  wire logic        div_no_refetch,
   input  wire logic [2:0]  stack_pop_kind,
   input  wire logic [15:0] stack_ptr,
   output logic             req_done,
   output logic             core_clock_en,
   input  wire logic        wait_n_pin,
   input  wire logic        bus_request_n_pin,
   input  wire logic        ext_prog_sel_pin,
   output bus_out_s         bus_out,
   output logic             ctrl_oe,
   output logic             port_oe,
   output logic             bus_ack_n,
   output logic [2:0]       port_ctrl,
   output logic [7:0]       port_data,
   output logic             onchip_prog_disable,
   output logic             timer_watchdog_select
);

   logic [7:0] wait_state_control_q;
   logic [1:0] mode_control_reg_q;
   logic       wait_input_enable_q;
   logic       wait_s1_q, wait_s2_q;
   logic       bus_request_in_s1_q, bus_request_in_s2_q;
   logic       strap_s1_q, strap_s2_q;
   logic       strap_taken_q;
   logic       ext_prog_q;
   cyc_state_e state_q;
   logic [2:0] pcnt_q;
   logic [1:0] rcnt_q;
   access_req_s cur_q;
   logic [2:0] extra_q;
   logic [15:0] extra_addr_q;
   logic       extra_prog_q;
   bus_out_s   bus_q;

   function automatic logic is_ext(input access_req_s r, input logic ext_prog);
      return r.external | (r.program_space & ext_prog);
   endfunction

   // APB slave, zero wait state
   logic apb_wr, apb_rd;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign apb_wr  = psel & penable & pwrite;
   assign apb_rd  = psel & ~penable & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_state_control_q <= WSC_RESET;
      end else if (apb_wr && paddr == WSC_OFFSET) begin
         wait_state_control_q <= pwdata[7:0] & WSC_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_control_reg_q  <= MODE_RESET;
         wait_input_enable_q <= 1'b0;
      end else if (apb_wr) begin
         if (paddr == MODE_OFFSET) begin
            mode_control_reg_q <= pwdata[1:0];
         end
         if (paddr == EXT_IRQ_VECTOR_REG_OFFSET) begin
            wait_input_enable_q <= pwdata[WAIT_EN_BIT];
         end
      end
   end

   // Read data registered in setup so it is stable in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd) begin
         case (paddr)
            WSC_OFFSET:  prdata <= {24'h00_0000, 1'b0, wait_state_control_q[6:0]};
            MODE_OFFSET: prdata <= {30'h0000_0000, mode_control_reg_q};
            EXT_IRQ_VECTOR_REG_OFFSET: prdata <= {31'h0000_0000, wait_input_enable_q};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign timer_watchdog_select = wait_state_control_q[WDG_BIT];

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_s1_q  <= 1'b1;
         wait_s2_q  <= 1'b1;
         bus_request_in_s1_q  <= 1'b1;
         bus_request_in_s2_q  <= 1'b1;
         strap_s1_q <= 1'b1;
         strap_s2_q <= 1'b1;
      end else begin
         wait_s1_q  <= wait_n_pin;
         wait_s2_q  <= wait_s1_q;
         bus_request_in_s1_q  <= bus_request_n_pin;
         bus_request_in_s2_q  <= bus_request_in_s1_q;
         strap_s1_q <= ext_prog_sel_pin;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Strap caught once after release, once synchronised
   logic [1:0] strap_age_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_age_q   <= 2'h0;
         strap_taken_q <= 1'b0;
         ext_prog_q    <= ~HAS_ONCHIP_PROG;
      end else if (!strap_taken_q) begin
         strap_age_q <= strap_age_q + 2'h1;
         if (strap_age_q == 2'h2) begin
            strap_taken_q <= 1'b1;
            ext_prog_q    <= ~HAS_ONCHIP_PROG | ~strap_s2_q;
         end
      end
   end
   assign onchip_prog_disable = ext_prog_q;

   // Port reset configuration follows the strap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_ctrl <= PORT_CTRL_ONCHIP;
         port_data <= 8'hff;
      end else if (strap_taken_q && ext_prog_q) begin
         port_ctrl <= PORT_CTRL_EXTPROG;
      end
   end

   logic wait_active;
   logic bus_request_in_active;
   assign wait_active = wait_input_enable_q & ~wait_s2_q;
   assign bus_request_in_active = mode_control_reg_q[BUS_REQ_EN_BIT] & ~bus_request_in_s2_q;

   logic [2:0] prog_cnt;
   assign prog_cnt = cur_q.program_space ? wait_state_control_q[PROG_LSB +: 3]
                                         : wait_state_control_q[DATA_LSB +: 3];

   // Access cycle sequencer; a fresh request or a queued spurious read starts T1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q      <= ST_IDLE;
         pcnt_q       <= 3'h0;
         rcnt_q       <= 2'h0;
         cur_q        <= '0;
         extra_q      <= 3'h0;
         extra_addr_q <= 16'h0000;
         extra_prog_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (extra_q != 3'h0) begin
                  cur_q   <= '{valid: 1'b1, external: 1'b1, program_space: extra_prog_q,
                               write: 1'b0, addr: extra_addr_q};
                  extra_q <= extra_q - 3'h1;
                  state_q <= ST_T1;
               end else if (req.valid) begin
                  cur_q   <= req;
                  state_q <= ST_T1;
                  if (div_done && !div_no_refetch) begin
                     extra_q      <= 3'(PREFETCH_DIV - 2'h1);
                     extra_addr_q <= req.addr;
                     extra_prog_q <= 1'b1;
                  end else if (stack_pop_kind != 3'h0) begin
                     extra_q      <= stack_pop_kind;
                     extra_addr_q <= stack_ptr;
                     extra_prog_q <= 1'b0;
                  end
               end
            end
            ST_T1: state_q <= ST_T2;
            ST_T2: begin
               if (!is_ext(cur_q, ext_prog_q)) begin
                  state_q <= ST_T3;
               end else if (prog_cnt != 3'h0) begin
                  pcnt_q  <= prog_cnt - 3'h1;
                  state_q <= ST_PWAIT;
               end else if (wait_active) begin
                  state_q <= ST_EWAIT;
               end else begin
                  state_q <= ST_T3;
               end
            end
            ST_PWAIT: begin
               if (pcnt_q != 3'h0) begin
                  pcnt_q <= pcnt_q - 3'h1;
               end else if (wait_active) begin
                  state_q <= ST_EWAIT;
               end else begin
                  state_q <= ST_T3;
               end
            end
            ST_EWAIT: begin
               if (!wait_active) begin
                  state_q <= ST_T3;
               end
            end
            ST_T3: begin
               if (bus_request_in_active) begin
                  state_q <= ST_FLOAT;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            ST_FLOAT: begin
               if (!bus_request_in_active) begin
                  rcnt_q  <= REBUS_CYCLES - 2'h1;
                  state_q <= ST_REDRV;
               end
            end
            ST_REDRV: begin
               if (rcnt_q != 2'h0) begin
                  rcnt_q <= rcnt_q - 2'h1;
               end else begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Spurious reads complete silently; only the real access is acknowledged
   logic real_access_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         real_access_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         real_access_q <= (extra_q == 3'h0) & req.valid;
      end
   end
   assign req_done = (state_q == ST_T3) & real_access_q;
   assign core_clock_en = ~(state_q inside {ST_PWAIT, ST_EWAIT, ST_FLOAT, ST_REDRV});

   // Bus pin drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_q <= '{address_strobe_n: 1'b1, data_strobe_n: 1'b1, read_write: 1'b1,
                    prog_data: 1'b1, opcode_fetch_cycle: 1'b0,
                    second_byte_fetch_cycle: 1'b0, addr: 16'h0000};
      end else begin
         bus_q.address_strobe_n <= ~(state_q == ST_IDLE & (req.valid | extra_q != 3'h0));
         if (state_q == ST_T1) begin
            bus_q.addr                    <= cur_q.addr;
            bus_q.read_write              <= ~cur_q.write;
            bus_q.prog_data               <= cur_q.program_space;
            bus_q.opcode_fetch_cycle      <= req_opcode & real_access_q;
            bus_q.second_byte_fetch_cycle <= req_second & real_access_q;
         end
         bus_q.data_strobe_n <= ~(is_ext(cur_q, ext_prog_q) &
                                  (state_q inside {ST_T1, ST_T2, ST_PWAIT, ST_EWAIT}));
      end
   end
   assign bus_out = bus_q;

   logic floated;
   assign floated   = state_q == ST_FLOAT;
   assign bus_ack_n = ~floated;
   assign ctrl_oe   = ~floated & ~mode_control_reg_q[BUS_FLOAT_BIT];
   assign port_oe   = ctrl_oe & (port_ctrl == PORT_CTRL_EXTPROG);

   // Assertions
   a_onchip_no_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_T2 && !is_ext(cur_q, ext_prog_q)) |=> state_q == ST_T3)
      else $error("on-chip access stretched");
   a_float_ack: assert property (@(posedge pclk) disable iff (!presetn)
      floated |-> (!bus_ack_n && !ctrl_oe && !core_clock_en))
      else $error("floated bus without acknowledge");
   a_redrive_two: assert property (@(posedge pclk) disable iff (!presetn)
      (floated && !bus_request_in_active) |=> (state_q == ST_REDRV)[*2] ##1 state_q == ST_IDLE)
      else $error("redrive not two cycles");
   a_prog_wait_len: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_T2 && is_ext(cur_q, ext_prog_q) && prog_cnt == 3'h7)
      |=> (state_q == ST_PWAIT)[*7])
      else $error("programmed wait length wrong");
   a_ewait_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_EWAIT && wait_active) |=> state_q == ST_EWAIT)
      else $error("wait released early");
   a_wait_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_EWAIT) |-> $past(wait_input_enable_q))
      else $error("wait without enable");
   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !wait_state_control_q[7])
      else $error("reserved bit set");
   a_ds_internal: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_T3 && !is_ext(cur_q, ext_prog_q)) |=> bus_q.data_strobe_n)
      else $error("strobe on internal access");
   a_float_bit: assert property (@(posedge pclk) disable iff (!presetn)
      mode_control_reg_q[BUS_FLOAT_BIT] |-> (!ctrl_oe && !port_oe))
      else $error("float bit ignored");
   a_ds_external: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_T2 && is_ext(cur_q, ext_prog_q)) |-> !bus_q.data_strobe_n)
      else $error("strobe missing on external access");
   a_stretch_ext: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q inside {ST_PWAIT, ST_EWAIT}) |-> is_ext(cur_q, ext_prog_q))
      else $error("wait cycle on internal access");
   a_zero_count: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_T2 && is_ext(cur_q, ext_prog_q) && prog_cnt == 3'h0 && !wait_active) |=> state_q == ST_T3)
      else $error("zero count still stretched");
   a_one_count: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_T2 && is_ext(cur_q, ext_prog_q) && prog_cnt == 3'h1) |=> state_q == ST_PWAIT ##1 state_q != ST_PWAIT)
      else $error("single wait length wrong");
   a_wait_appended: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_PWAIT && pcnt_q == 3'h0 && wait_active) |=> state_q == ST_EWAIT)
      else $error("external wait not appended");
   // Float may only start at the end of an access, never mid-cycle
   a_float_entry: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q != ST_FLOAT && state_q != ST_T3) |=> !floated)
      else $error("bus floated outside phase three");
   a_float_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (floated && bus_request_in_active) |=> floated)
      else $error("bus taken back while requested");
   a_redrive_drive: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_REDRV && !mode_control_reg_q[BUS_FLOAT_BIT]) |-> (ctrl_oe && !core_clock_en))
      else $error("redrive cycle not driving");
   // Strap is caught once; later pin activity must not move it
   a_strap_stable: assert property (@(posedge pclk) disable iff (!presetn)
      strap_taken_q |=> $stable(ext_prog_q))
      else $error("strap changed after capture");
   a_port_extprog: assert property (@(posedge pclk) disable iff (!presetn)
      (strap_taken_q && ext_prog_q) |=> port_ctrl == PORT_CTRL_EXTPROG)
      else $error("ports not in address mode");
   a_spur_read: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE && extra_q != 3'h0) |=> (state_q == ST_T1 && !cur_q.write))
      else $error("queued spurious read not started");
endmodule

// ===== verification/ext_mem_model.sv
// Slow external memory and second bus master facing the controller
module ext_mem_model
   import ext_mem_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire bus_out_s   bus_out,
   input  wire logic       ctrl_oe,
   input  wire logic [3:0] stretch,
   input  wire logic       grab,
   output logic            wait_n_pin,
   output logic            bus_request_n_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] hold_q;
   logic       as_n_q;
   // Wait held low from address strobe until the slow part is ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 4'h0;
         as_n_q <= 1'b1;
      end else begin
         as_n_q <= bus_out.address_strobe_n;
         if (as_n_q && !bus_out.address_strobe_n && ctrl_oe)
            hold_q <= stretch;
         else if (hold_q != 4'h0)
            hold_q <= hold_q - 4'h1;
      end
   end
   assign wait_n_pin = (hold_q == 4'h0);
   // Other master keeps its request low until it gives the bus back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         bus_request_n_pin <= 1'b1;
      else
         bus_request_n_pin <= !grab;
   end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the external memory wait and bus sharing controller
module tb_top
   import ext_mem_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, req_done, core_clock_en, wait_n_pin, bus_request_n_pin;
   access_req_s req = '0;
   logic        req_opcode = 0, req_second = 0, div_done = 0, div_no_refetch = 0;
   logic [2:0]  stack_pop_kind = 3'h0;
   logic [15:0] stack_ptr = 16'h8040;
   logic        ext_prog_sel_pin = 1, ctrl_oe, port_oe, bus_ack_n;
   bus_out_s    bus_out;
   logic [2:0]  port_ctrl;
   logic [7:0]  port_data;
   logic        onchip_prog_disable, timer_watchdog_select, grab = 0, ds_q = 1, seen_m1 = 0, seen_m2 = 0;
   logic [3:0]  stretch = 4'h0;
   logic [16:0] pop_seen = 17'h0_0000;
   int          fails = 0, n_tests = 0, ds_falls = 0, pd_falls = 0, base = 0;

   always #5 pclk = ~pclk;

   ext_mem_bus_wait_share dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .req(req), .req_opcode(req_opcode), .req_second(req_second),
      .div_done(div_done), .div_no_refetch(div_no_refetch), .stack_pop_kind(stack_pop_kind),
      .stack_ptr(stack_ptr), .req_done(req_done), .core_clock_en(core_clock_en),
      .wait_n_pin(wait_n_pin), .bus_request_n_pin(bus_request_n_pin),
      .ext_prog_sel_pin(ext_prog_sel_pin), .bus_out(bus_out), .ctrl_oe(ctrl_oe), .port_oe(port_oe),
      .bus_ack_n(bus_ack_n), .port_ctrl(port_ctrl), .port_data(port_data),
      .onchip_prog_disable(onchip_prog_disable), .timer_watchdog_select(timer_watchdog_select));
   ext_mem_model mem (.pclk(pclk), .presetn(presetn), .bus_out(bus_out), .ctrl_oe(ctrl_oe),
      .stretch(stretch), .grab(grab), .wait_n_pin(wait_n_pin), .bus_request_n_pin(bus_request_n_pin));

   // Counts strobe pulses, and those marked program space
   always @(posedge pclk) begin
      ds_q <= bus_out.data_strobe_n;
      if (ds_q === 1'b1 && bus_out.data_strobe_n === 1'b0) begin
         ds_falls++;
         if (bus_out.prog_data === 1'b1)
            pd_falls++;
         else
            pop_seen <= {bus_out.read_write, bus_out.addr};
      end
      if (bus_out.opcode_fetch_cycle === 1'b1)
         seen_m1 <= 1'b1;
      if (bus_out.second_byte_fetch_cycle === 1'b1)
         seen_m2 <= 1'b1;
   end

   task automatic test_done;
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tmo;
      fails++;
      $display("MISMATCH %0t wait ran out", $time);
      test_done();
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i >= 50)
         tmo();
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   // Starts one access and returns the cycles until its done pulse
   task automatic acc(input logic ext, input logic prog, output int lat);
      @(posedge pclk);
      req <= '{valid: 1'b1, external: ext, program_space: prog, write: 1'b0, addr: 16'h8000};
      lat = 0;
      do begin
         @(posedge pclk);
         lat++;
      end while (req_done !== 1'b1 && lat < 300);
      if (lat >= 300)
         tmo();
      req <= '0;
      div_done <= 1'b0;
      stack_pop_kind <= 3'h0;
   endtask
   task automatic wait_ack(input logic v);
      for (int i = 0; i < 300 && bus_ack_n !== v; i++)
         @(posedge pclk);
      if (bus_ack_n !== v)
         tmo();
   endtask

   task automatic t_regs;
      logic [31:0] q;
      apb(1'b0, WSC_OFFSET, 32'h0, q);
      chk(q, 32'h0000_007f);
      apb(1'b0, MODE_OFFSET, 32'h0, q);
      chk(q, 32'h0);
      chk(32'(port_ctrl), 32'(PORT_CTRL_ONCHIP));
      chk(32'(port_data), 32'h0000_00ff);
      chk(32'(timer_watchdog_select), 32'h1);
      wr(WSC_OFFSET, 32'hffff_ffff);
      apb(1'b0, WSC_OFFSET, 32'h0, q);
      chk(q, 32'h0000_007f);
      wr(WSC_OFFSET, 32'h0000_0000);
      @(posedge pclk);
      chk(32'(timer_watchdog_select), 32'h0);
      wr(8'h10, 32'h0000_00a5);
      apb(1'b0, 8'h10, 32'h0, q);
      chk(q, 32'h0);
   endtask
   task automatic t_counts;
      int lp, ld;
      wr(WSC_OFFSET, 32'h0000_0040);
      acc(1'b1, 1'b1, base);
      chk(32'(base), 32'h4);
      for (int n = 0; n < 8; n++) begin
         wr(WSC_OFFSET, 32'h0000_0040 | 32'((7 - n) << 3) | 32'(n));
         acc(1'b1, 1'b1, lp);
         acc(1'b1, 1'b0, ld);
         chk(32'(lp), 32'(base + n));
         chk(32'(ld), 32'(base + 7 - n));
      end
      wr(WSC_OFFSET, 32'h0000_007f);
      ds_falls = 0;
      acc(1'b0, 1'b1, lp);
      chk(32'(lp), 32'(base));
      chk(32'(ds_falls), 32'h0);
   endtask
   task automatic t_wait;
      int l0, ld, l6, l8;
      wr(WSC_OFFSET, 32'h0000_0042);
      acc(1'b1, 1'b1, l0);
      stretch <= 4'h8;
      acc(1'b1, 1'b1, ld);
      chk(32'(ld), 32'(l0));
      wr(EXT_IRQ_VECTOR_REG_OFFSET, 32'h0000_0001);
      stretch <= 4'h6;
      acc(1'b1, 1'b1, l6);
      chk(32'(l6 > l0), 32'h1);
      stretch <= 4'h8;
      acc(1'b1, 1'b1, l8);
      chk(32'(l8 - l6), 32'h2);
      acc(1'b0, 1'b1, ld);
      chk(32'(ld), 32'(base));
      stretch <= 4'h0;
      wr(EXT_IRQ_VECTOR_REG_OFFSET, 32'h0);
      wr(WSC_OFFSET, 32'h0000_0040);
   endtask
   task automatic t_share;
      int l, n;
      grab <= 1'b1;
      acc(1'b1, 1'b1, l);
      repeat (8) @(posedge pclk);
      chk(32'(bus_ack_n), 32'h1);
      wr(MODE_OFFSET, 32'h0000_0002);
      acc(1'b1, 1'b1, l);
      wait_ack(1'b0);
      chk(32'({ctrl_oe, port_oe, core_clock_en}), 32'h0);
      repeat (6) @(posedge pclk);
      chk(32'(bus_ack_n), 32'h0);
      grab <= 1'b0;
      wait_ack(1'b1);
      for (n = 0; n < 20 && core_clock_en !== 1'b1; n++)
         @(posedge pclk);
      chk(32'(n), 32'(REBUS_CYCLES));
      chk(32'(ctrl_oe), 32'h1);
      wr(MODE_OFFSET, 32'h0000_0001);
      @(posedge pclk);
      chk(32'(ctrl_oe), 32'h0);
      acc(1'b0, 1'b1, l);
      chk(32'(l), 32'(base));
      wr(MODE_OFFSET, 32'h0);
   endtask
   task automatic t_spur;
      int l;
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         ds_falls = 0;
         pd_falls = 0;
         div_done <= 1'b1;
         div_no_refetch <= k[0];
         acc(1'b1, 1'b1, l);
         acc(1'b0, 1'b1, l);
         chk(32'(ds_falls), 32'(2 - k));
         chk(32'(pd_falls), 32'(2 - k));
      end
      div_no_refetch <= 1'b0;
      // Byte pop, return and interrupt return in turn
      for (int k = 1; k < 4; k++) begin
         @(posedge pclk);
         ds_falls = 0;
         pd_falls = 0;
         stack_pop_kind <= 3'(k);
         acc(1'b0, 1'b1, l);
         acc(1'b0, 1'b1, l);
         chk(32'(ds_falls), 32'(k));
         chk(32'(pd_falls), 32'h0);
         chk(32'(pop_seen), 32'({1'b1, stack_ptr}));
      end
      req_opcode <= 1'b1;
      req_second <= 1'b1;
      acc(1'b1, 1'b1, l);
      req_opcode <= 1'b0;
      req_second <= 1'b0;
      chk(32'({seen_m1, seen_m2}), 32'h3);
   endtask
   // Strap sampled low at the end of a second reset
   task automatic t_strap;
      presetn <= 1'b0;
      ext_prog_sel_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(32'(onchip_prog_disable), 32'h1);
      chk(32'(port_ctrl), 32'(PORT_CTRL_EXTPROG));
      chk(32'(port_data), 32'h0000_00ff);
   endtask

   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_counts();
      t_wait();
      t_share();
      t_spur();
      t_strap();
      test_done();
   end
endmodule
